// ---- common/stack_ptr_map.vh ----
`ifndef STACK_PTR_MAP_VH
`define STACK_PTR_MAP_VH
`define SP_ADDR_W 16
`define SP_REG_CNT 8
`define SP_SEL_W 3
`define SP_HW_STACK_REG 3'h6
`define SP_PC_REG 3'h7
`define SP_STEP_WORD 16'h0002
`define SP_STEP_BYTE 16'h0001
`define SP_WORD_MASK 16'hfffe
`define SP_RESET_VAL 16'h0000
`define SP_OP_NONE 2'h0
`define SP_OP_PUSH 2'h1
`define SP_OP_POP 2'h2
`define SP_OP_LOAD 2'h3
`define SP_ST_IDLE 2'h0
`define SP_ST_WAIT 2'h1
`endif

// ---- verilog/stack_ptr_unit.v ----
`timescale 1ns/1ps
`default_nettype none
`include "stack_ptr_map.vh"
module stack_ptr_unit
(
    // Clock and reset
    input wire sys_clk_i,
    input wire nrst_i,
    // Stack operation request
    input wire op_valid_i,
    output wire op_ready_o,
    input wire [1:0] op_i,
    input wire [`SP_SEL_W-1:0] op_reg_i,
    input wire op_implicit_i,
    input wire op_byte_i,
    input wire [15:0] op_wdata_i,
    // Operation result
    output reg done_ff_o,
    output reg illegal_ff_o,
    output reg [15:0] rdata_ff_o,
    // Register read port
    input wire [`SP_SEL_W-1:0] rd_sel_i,
    output wire [15:0] rd_data_o,
    // Memory holding the stack
    output reg mem_req_ff_o,
    output reg mem_we_ff_o,
    output reg mem_byte_ff_o,
    output reg [15:0] mem_addr_ff_o,
    output reg [15:0] mem_wdata_ff_o,
    input wire mem_ack_i,
    input wire [15:0] mem_rdata_i
);
    // Controller states
    localparam [1:0] ST_IDLE = `SP_ST_IDLE;
    localparam [1:0] ST_WAIT = `SP_ST_WAIT;

    reg [15:0] ptr_ff [0:`SP_REG_CNT-1];
    reg [1:0] state_ff;
    reg [1:0] pend_op_ff;
    reg [`SP_SEL_W-1:0] pend_reg_ff;
    reg [15:0] pend_step_ff;
    reg [1:0] nxt_state;
    integer i;

    wire [`SP_SEL_W-1:0] eff_reg;
    wire [15:0] step;
    wire [15:0] cur_ptr;
    wire [15:0] dec_ptr;
    wire [15:0] inc_ptr;
    wire [15:0] load_val;
    wire is_illegal;
    wire take;
    wire take_ok;
    wire do_push;
    wire do_pop;
    wire do_load;
    wire mem_done;
    wire pop_done;
    wire bad_state;

    // Step size per register and access width
    function [15:0] step_of;
        input [`SP_SEL_W-1:0] r;
        input b;
        begin
            if (b && r != `SP_HW_STACK_REG && r != `SP_PC_REG)
                step_of = `SP_STEP_BYTE;
            else
                step_of = `SP_STEP_WORD;
        end
    endfunction

    // Push and pop are the only codes that touch memory
    function is_stack_op;
        input [1:0] o;
        begin
            is_stack_op = (o == `SP_OP_PUSH) || (o == `SP_OP_POP);
        end
    endfunction

    assign eff_reg = op_implicit_i ? `SP_HW_STACK_REG : op_reg_i;
    assign step = step_of(eff_reg, op_byte_i);
    assign cur_ptr = ptr_ff[eff_reg];
    assign dec_ptr = cur_ptr - step;
    // Pop moves the pointer it captured, not the one now requested
    assign inc_ptr = ptr_ff[pend_reg_ff] + pend_step_ff;
    // Hardware stack register may only hold even addresses
    assign load_val = (eff_reg == `SP_HW_STACK_REG) ?
        (op_wdata_i & `SP_WORD_MASK) : op_wdata_i;
    // Stack ops through the program counter register are refused
    assign is_illegal = is_stack_op(op_i) && eff_reg == `SP_PC_REG;
    assign op_ready_o = (state_ff == ST_IDLE);
    assign rd_data_o = ptr_ff[rd_sel_i];

    assign take = op_valid_i && op_ready_o;
    assign take_ok = take && !is_illegal;
    assign do_push = take_ok && op_i == `SP_OP_PUSH;
    assign do_pop = take_ok && op_i == `SP_OP_POP;
    assign do_load = take_ok && op_i == `SP_OP_LOAD;
    assign mem_done = (state_ff == ST_WAIT) && mem_ack_i;
    assign pop_done = mem_done && pend_op_ff == `SP_OP_POP;
    assign bad_state = (state_ff != ST_IDLE) && (state_ff != ST_WAIT);

    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
                if (take_ok && is_stack_op(op_i))
                    nxt_state = ST_WAIT;
            ST_WAIT:
                if (mem_ack_i)
                    nxt_state = ST_IDLE;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    // Controller state
    always @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // Pointer registers; push moves before the access, pop after it
    always @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            for (i = 0; i < `SP_REG_CNT; i = i + 1)
                ptr_ff[i] <= `SP_RESET_VAL;
        end
        else if (do_push)
            ptr_ff[eff_reg] <= dec_ptr;
        else if (do_load)
            ptr_ff[eff_reg] <= load_val;
        else if (pop_done)
            ptr_ff[pend_reg_ff] <= inc_ptr;
    end

    // Access held for the memory handshake
    always @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pend_op_ff <= `SP_OP_NONE;
            pend_reg_ff <= {`SP_SEL_W{1'b0}};
            pend_step_ff <= `SP_STEP_WORD;
        end
        else if (take_ok)
        begin
            pend_op_ff <= op_i;
            pend_reg_ff <= eff_reg;
            pend_step_ff <= step;
        end
    end

    // Memory request, held until the memory acknowledges
    always @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mem_req_ff_o <= 1'b0;
            mem_we_ff_o <= 1'b0;
            mem_byte_ff_o <= 1'b0;
            mem_addr_ff_o <= `SP_RESET_VAL;
            mem_wdata_ff_o <= `SP_RESET_VAL;
        end
        else if (take_ok)
        begin
            if (do_push)
            begin
                mem_addr_ff_o <= dec_ptr;
                mem_we_ff_o <= 1'b1;
                mem_req_ff_o <= 1'b1;
            end
            else if (do_pop)
            begin
                mem_addr_ff_o <= cur_ptr;
                mem_we_ff_o <= 1'b0;
                mem_req_ff_o <= 1'b1;
            end
            mem_byte_ff_o <= (step == `SP_STEP_BYTE);
            mem_wdata_ff_o <= op_wdata_i;
        end
        else if (mem_done)
        begin
            mem_req_ff_o <= 1'b0;
            mem_we_ff_o <= 1'b0;
        end
        else if (bad_state)
            mem_req_ff_o <= 1'b0;
    end

    // Completion pulses and pop data
    always @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            done_ff_o <= 1'b0;
            illegal_ff_o <= 1'b0;
            rdata_ff_o <= `SP_RESET_VAL;
        end
        else
        begin
            // Memory ops finish on acknowledge, the rest at once
            done_ff_o <= (take && (is_illegal || !is_stack_op(op_i)))
                || mem_done;
            illegal_ff_o <= take && is_illegal;
            if (pop_done)
                rdata_ff_o <= mem_rdata_i;
        end
    end
endmodule // stack_ptr_unit
`default_nettype wire

// ---- test/stack_ptr_unit_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module stack_ptr_unit_sva(
    input wire sys_clk_i, nrst_i, op_valid_i, op_ready_o, op_implicit_i,
    input wire op_byte_i, done_ff_o, illegal_ff_o, mem_req_ff_o,
    input wire mem_we_ff_o, mem_byte_ff_o, mem_ack_i,
    input wire [1:0] op_i,
    input wire [2:0] op_reg_i, rd_sel_i,
    input wire [15:0] rd_data_o, rdata_ff_o, mem_addr_ff_o, mem_rdata_i
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    wire tk = op_valid_i && op_ready_o && !op_implicit_i &&
        op_reg_i == rd_sel_i && op_reg_i < 3'h6 && op_i == 2'h1;
    sequence acc_end;
        mem_req_ff_o && mem_ack_i;
    endsequence
    sequence pop_end;
        acc_end ##0 (!mem_we_ff_o && !mem_byte_ff_o);
    endsequence
    push_word_a: assert property (tk && !op_byte_i |=>
        rd_data_o == $past(rd_data_o) - 16'h2 && mem_addr_ff_o == rd_data_o)
        else $error("word push step wrong");
    push_byte_a: assert property (tk && op_byte_i |=>
        rd_data_o == $past(rd_data_o) - 16'h1) else $error("byte step wrong");
    pop_inc_a: assert property (pop_end |=>
        rd_data_o == $past(mem_addr_ff_o) + 16'h2 &&
        rdata_ff_o == $past(mem_rdata_i)) else $error("pop wrong");
    pc_refused_a: assert property (op_valid_i && op_ready_o &&
        op_reg_i == 3'h7 && !op_implicit_i && ^op_i |=> illegal_ff_o &&
        done_ff_o && !mem_req_ff_o) else $error("pc stack not refused");
    req_hold_a: assert property (mem_req_ff_o && !mem_ack_i |=>
        mem_req_ff_o) else $error("request dropped");
    req_end_a: assert property (acc_end |=> !mem_req_ff_o && done_ff_o)
        else $error("access end wrong");
    done_pulse_a: assert property (done_ff_o && !op_valid_i |=> !done_ff_o)
        else $error("done too long");
    hw_even_a: assert property (rd_sel_i == 3'h6 |-> !rd_data_o[0])
        else $error("hardware pointer odd");
endmodule // stack_ptr_unit_sva
bind stack_ptr_unit stack_ptr_unit_sva stack_ptr_unit_sva_i(.*);
`default_nettype wire

// ---- test/stack_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module stack_mem_model(
    input wire sys_clk_i, mem_req_ff_o, mem_we_ff_o, mem_byte_ff_o,
    input wire [15:0] mem_addr_ff_o, mem_wdata_ff_o,
    input wire [3:0] wait_i,
    output logic mem_ack_i,
    output logic [15:0] mem_rdata_i
);
    logic [7:0] m [0:255];
    logic [3:0] cnt = 4'h0;
    wire [7:0] a = mem_addr_ff_o[7:0];
    wire go = mem_req_ff_o && !mem_ack_i && cnt >= wait_i;
    initial mem_ack_i = 1'h0;
    initial mem_rdata_i = 16'h0000;
    always @(posedge sys_clk_i)
    begin
        cnt <= (mem_req_ff_o && !mem_ack_i) ? cnt + 4'h1 : 4'h0;
        mem_ack_i <= go;
        // Read data only valid with the acknowledge
        mem_rdata_i <= ~mem_rdata_i;
        if (go && !mem_we_ff_o)
            mem_rdata_i <= {m[a + 8'h1], m[a]};
        if (go && mem_we_ff_o)
            m[a] <= mem_wdata_ff_o[7:0];
        if (go && mem_we_ff_o && !mem_byte_ff_o)
            m[a + 8'h1] <= mem_wdata_ff_o[15:8];
    end
endmodule // stack_mem_model
`default_nettype wire

// ---- test/stack_ptr_unit_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module stack_ptr_unit_test;
    logic sys_clk_i, nrst_i, op_valid_i, op_implicit_i, op_byte_i;
    logic [1:0] op_i;
    logic [2:0] op_reg_i, rd_sel_i;
    logic [15:0] op_wdata_i;
    logic [3:0] wait_i;
    wire op_ready_o, done_ff_o, illegal_ff_o, mem_req_ff_o, mem_we_ff_o;
    wire mem_byte_ff_o, mem_ack_i;
    wire [15:0] rdata_ff_o, rd_data_o, mem_addr_ff_o, mem_wdata_ff_o;
    wire [15:0] mem_rdata_i;
    integer errors, n_tests;
    stack_ptr_unit stack_ptr_unit_i(.*);
    stack_mem_model stack_mem_model_i(.*);
    always #12.5 sys_clk_i = ~sys_clk_i;
    task final_report;
    begin
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    task chk(input [15:0] s, input [15:0] e);
    begin
        n_tests = n_tests + 1;
        if (s !== e)
        begin
            errors = errors + 1;
            $display("CHECK FAILED t=%0t %h %h", $time, s, e);
        end
    end
    endtask
    // Flags f = {implicit, byte}
    task op(input [1:0] o, input [2:0] r, input [1:0] f, input [15:0] d);
        integer k;
    begin
        @(negedge sys_clk_i);
        {op_valid_i, op_i, op_reg_i} = {1'h1, o, r};
        {op_implicit_i, op_byte_i} = f;
        op_wdata_i = d;
        rd_sel_i = f[1] ? 3'h6 : r;
        @(negedge sys_clk_i);
        op_valid_i = 1'h0;
        for (k = 0; k < 40 && done_ff_o !== 1'h1; k = k + 1)
            @(negedge sys_clk_i);
        if (done_ff_o !== 1'h1)
        begin
            errors = errors + 1;
            final_report;
        end
    end
    endtask
    task t_word;
    begin
        op(2'h3, 3'h3, 2'h0, 16'h0100);
        op(2'h1, 3'h3, 2'h0, 16'h1234);
        op(2'h1, 3'h3, 2'h0, 16'hbeef);
        chk(mem_addr_ff_o, 16'h00fc);
        op(2'h2, 3'h3, 2'h0, 16'h0000);
        chk(rdata_ff_o, 16'hbeef);
        op(2'h2, 3'h3, 2'h0, 16'h0000);
        chk(rdata_ff_o, 16'h1234);
        chk(rd_data_o, 16'h0100);
        op(2'h0, 3'h3, 2'h0, 16'hffff);
        chk(rd_data_o, 16'h0100);
        $display("word stack done");
    end
    endtask
    task t_byte;
    begin
        wait_i = 4'h5;
        op(2'h3, 3'h2, 2'h0, 16'h0051);
        op(2'h1, 3'h2, 2'h1, 16'h005a);
        chk(rd_data_o, 16'h0050);
        chk({15'h0, mem_byte_ff_o}, 16'h0001);
        op(2'h2, 3'h2, 2'h1, 16'h0000);
        chk({8'h00, rdata_ff_o[7:0]}, 16'h005a);
        chk(rd_data_o, 16'h0051);
        $display("byte stack done");
    end
    endtask
    task t_hw;
    begin
        op(2'h3, 3'h6, 2'h0, 16'h0081);
        chk(rd_data_o, 16'h0080);
        op(2'h1, 3'h1, 2'h3, 16'h00aa);
        chk(rd_data_o, 16'h007e);
        chk({15'h0, mem_byte_ff_o}, 16'h0000);
        rd_sel_i = 3'h1;
        #1 chk(rd_data_o, 16'h0000);
        op(2'h2, 3'h1, 2'h2, 16'h0000);
        chk({8'h00, rdata_ff_o[7:0]}, 16'h00aa);
        op(2'h1, 3'h7, 2'h0, 16'h0001);
        chk({15'h0, illegal_ff_o}, 16'h0001);
        chk({15'h0, mem_req_ff_o}, 16'h0000);
        chk({15'h0, op_ready_o}, 16'h0001);
        $display("hardware stack done");
    end
    endtask
    initial
    begin
        {sys_clk_i, nrst_i, op_valid_i, op_i, op_reg_i} = 7'h00;
        {op_implicit_i, op_byte_i, op_wdata_i, rd_sel_i, wait_i} = 25'h0;
        errors = 0;
        n_tests = 0;
        repeat (5) @(negedge sys_clk_i);
        nrst_i = 1'h1;
        t_word;
        t_byte;
        t_hw;
        final_report;
    end
endmodule // stack_ptr_unit_test
`default_nettype wire
